// [rtl/cpa_proc.sv]
// Processor end: opcode check and coprocessor access engine.
//
// Our own choice: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module cpa_proc
    import cpa_pkg::*;
(
    // Clock and reset
    input  wire logic        MCLK,
    input  wire logic        RESETN,
    // Wishbone slave
    input  wire logic        WB_CYC,
    input  wire logic        WB_STB,
    input  wire logic        WB_WE,
    input  wire logic [7:0]  WB_ADR,
    input  wire logic [3:0]  WB_SEL,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK,
    // Bus towards the coprocessors and memory
    cpa_bus_if.proc          BUS
);
    cpa_bus_state_t bs_r;
    logic [15:0] opword_r;
    logic [31:0] data_r;
    logic [31:0] maddr_r;
    logic [31:0] cmd_r;
    logic [15:0] ext_r;
    logic [7:0]  ext_cnt_r;
    logic        busy_r;
    logic        phase_r;
    logic        unimpl_r;
    logic        refused_r;
    logic        as_r;
    logic        rw_r;
    logic [2:0]  fc_r;
    logic [31:0] addr_r;
    logic [31:0] wdo_r;
    logic        woe_r;

    logic        fline;
    logic [2:0]  coprocessor_identifier_field;
    logic        copro_ok;
    logic        wr_take;
    logic [31:0] wmask;
    logic [31:0] wval;
    logic        cmd_go;
    logic        cmd_bad;
    logic        wr_status;
    logic [2:0]  op;
    logic [4:0]  csel;
    logic [4:0]  step_sel;
    logic        step_cir;
    logic        step_rd;
    logic        two_phase;
    logic [31:0] step_addr;
    logic [2:0]  step_fc;
    logic [31:0] read_val;

    assign fline    = opword_r[15:12] == FLINE_PREFIX;
    assign coprocessor_identifier_field     = opword_r[11:9];
    assign copro_ok = fline && (coprocessor_identifier_field != COPROCESSOR_IDENTIFIER_FIELD_NONE);

    // Wishbone: writes take effect on the edge that sees ack high.
    assign wr_take = WB_CYC && WB_STB && WB_WE && WB_ACK;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_lane
            assign wmask[gi*8 +: 8] = {8{WB_SEL[gi]}};
        end
    endgenerate
    assign wval      = WB_DAT_I & wmask;
    assign wr_status = wr_take && (WB_ADR == WB_STATUS);
    assign cmd_go    = wr_take && (WB_ADR == WB_CMD);
    assign op        = wval[CMD_OP_LSB +: 3];
    // Coprocessor commands need a valid identifier; none may overlap.
    assign cmd_bad   = busy_r || (op > OP_ALT_MOVE) ||
                       ((op != OP_ALT_MOVE) && !copro_ok);

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            WB_ACK   <= 1'b0;
            WB_DAT_O <= RST_WORD;
        end else begin
            WB_ACK   <= WB_CYC && WB_STB && !WB_ACK;
            case (WB_ADR)
                WB_OPWORD: WB_DAT_O <= {16'h0000, opword_r};
                WB_DATA:   WB_DAT_O <= data_r;
                WB_MADDR:  WB_DAT_O <= maddr_r;
                WB_CMD:    WB_DAT_O <= cmd_r;
                WB_STATUS: WB_DAT_O <= {8'h00, ext_cnt_r, 5'h00, coprocessor_identifier_field,
                                        3'h0, refused_r, unimpl_r,
                                        copro_ok, fline, busy_r};
                WB_EXT:    WB_DAT_O <= {16'h0000, ext_r};
                default:   WB_DAT_O <= RST_WORD;
            endcase
        end
    end

    // Operation word, extension words and sticky flags.
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            opword_r  <= RST_HALF;
            ext_r     <= RST_HALF;
            ext_cnt_r <= RST_COUNT;
            unimpl_r  <= 1'b0;
            refused_r <= 1'b0;
            maddr_r   <= RST_WORD;
        end else begin
            if (wr_take && (WB_ADR == WB_OPWORD)) begin
                opword_r  <= wval[15:0];
                ext_cnt_r <= RST_COUNT;
            end else if (wr_take && (WB_ADR == WB_EXT)) begin
                ext_r <= wval[15:0];
                if (ext_cnt_r != 8'hff) begin
                    ext_cnt_r <= ext_cnt_r + 8'h01;
                end
            end
            if (wr_take && (WB_ADR == WB_MADDR)) begin
                maddr_r <= wval;
            end
            // A fresh event wins over a simultaneous clear.
            if (wr_take && (WB_ADR == WB_OPWORD) &&
                (wval[15:12] == FLINE_PREFIX) &&
                (wval[11:9] == COPROCESSOR_IDENTIFIER_FIELD_NONE) && (wval[8:6] != 3'h0)) begin
                unimpl_r <= 1'b1;
            end else if (wr_status && wval[ST_UNIMPL_BIT]) begin
                unimpl_r <= 1'b0;
            end
            if (cmd_go && cmd_bad) begin
                refused_r <= 1'b1;
            end else if (wr_status && wval[ST_REFUSED_BIT]) begin
                refused_r <= 1'b0;
            end
        end
    end

    // Bus cycle the current command step needs.
    assign csel = cmd_r[CMD_SEL_LSB +: 5];
    always_comb begin
        step_sel  = csel;
        step_cir  = 1'b1;
        step_rd   = 1'b0;
        two_phase = 1'b0;
        case (cmd_r[CMD_OP_LSB +: 3])
            OP_CIR_WR: step_rd = 1'b0;
            OP_CIR_RD: step_rd = 1'b1;
            OP_START: begin
                case (cmd_r[CMD_CAT_LSB +: 2])
                    CAT_GENERAL: step_sel = CIR_COMMAND;
                    CAT_COND:    step_sel = CIR_CONDITION;
                    CAT_SAVE: begin
                        step_sel = CIR_SAVE;
                        step_rd  = 1'b1;
                    end
                    default:     step_sel = CIR_RESTORE;
                endcase
            end
            OP_OPND_OUT: begin
                two_phase = 1'b1;
                step_rd   = !phase_r;
                step_cir  = !phase_r;
            end
            OP_OPND_IN: begin
                two_phase = 1'b1;
                step_rd   = !phase_r;
                step_cir  = phase_r;
            end
            default: begin
                step_cir = 1'b0;
                step_rd  = cmd_r[CMD_RD_BIT];
            end
        endcase
        if (step_cir) begin
            step_fc   = FC_CPU_SPACE;
            step_addr = {12'h000, CYC_TYPE_COPRO, coprocessor_identifier_field,
                         8'h00, step_sel};
        end else begin
            step_fc   = cmd_r[CMD_FC_LSB +: 3];
            step_addr = maddr_r;
        end
    end

    // Halfword registers travel on the lane that address bit 1 picks.
    assign read_val = !(step_cir && cpa_is_half(step_sel)) ? BUS.data :
                      step_sel[1] ? {16'h0000, BUS.data[15:0]} :
                      {16'h0000, BUS.data[31:16]};

    // Access engine: one strobed cycle per step, closed by the answer.
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            bs_r    <= BS_IDLE;
            busy_r  <= 1'b0;
            phase_r <= 1'b0;
            cmd_r   <= RST_WORD;
            data_r  <= RST_WORD;
            as_r    <= 1'b0;
            rw_r    <= 1'b1;
            fc_r    <= 3'h0;
            addr_r  <= RST_WORD;
            wdo_r   <= RST_WORD;
            woe_r   <= 1'b0;
        end else begin
            if (wr_take && (WB_ADR == WB_DATA) && !busy_r) begin
                data_r <= wval;
            end
            if (cmd_go && !cmd_bad) begin
                cmd_r   <= wval;
                busy_r  <= 1'b1;
                phase_r <= 1'b0;
            end
            case (bs_r)
                BS_IDLE: begin
                    if (busy_r) begin
                        as_r   <= 1'b1;
                        fc_r   <= step_fc;
                        addr_r <= step_addr;
                        rw_r   <= step_rd;
                        woe_r  <= !step_rd;
                        wdo_r  <= (step_cir && cpa_is_half(step_sel)) ?
                                  {data_r[15:0], data_r[15:0]} : data_r;
                        bs_r   <= BS_WAIT_ACK;
                    end
                end
                BS_WAIT_ACK: begin
                    if (BUS.ack) begin
                        if (rw_r) begin
                            data_r <= read_val;
                        end
                        as_r  <= 1'b0;
                        woe_r <= 1'b0;
                        bs_r  <= BS_WAIT_REL;
                    end
                end
                BS_WAIT_REL: begin
                    if (!BUS.ack) begin
                        rw_r <= 1'b1;
                        bs_r <= BS_IDLE;
                        if (two_phase && !phase_r) begin
                            phase_r <= 1'b1;
                        end else begin
                            busy_r <= 1'b0;
                        end
                    end
                end
                default: bs_r <= BS_IDLE;
            endcase
        end
    end

    assign BUS.as        = as_r;
    assign BUS.rw        = rw_r;
    assign BUS.fc        = fc_r;
    assign BUS.addr      = addr_r;
    assign BUS.p_data_o  = wdo_r;
    assign BUS.p_data_oe = woe_r;
endmodule : cpa_proc
`default_nettype wire

// [rtl/cpa_pkg.sv]
// Shared constants, types and helpers for the coprocessor access block.
package cpa_pkg;

    // Function code and cycle type of a coprocessor access.
    localparam logic [2:0]  FC_CPU_SPACE   = 3'h7;
    localparam logic [3:0]  CYC_TYPE_COPRO = 4'h2;
    localparam logic [3:0]  FLINE_PREFIX   = 4'hf;
    localparam logic [2:0]  COPROCESSOR_IDENTIFIER_FIELD_NONE      = 3'h0;
    localparam logic [2:0]  USER_COPROCESSOR_IDENTIFIER_FIELD_DFLT = 3'h6;

    // Operation word fields.
    localparam int          OPW_PREFIX_LSB = 12;
    localparam int          OPW_COPROCESSOR_IDENTIFIER_FIELD_LSB   = 9;
    localparam int          OPW_TYPE_LSB   = 6;

    // Coprocessor interface register byte addresses within the region.
    localparam logic [4:0]  CIR_RESPONSE   = 5'h00;
    localparam logic [4:0]  CIR_CONTROL    = 5'h02;
    localparam logic [4:0]  CIR_SAVE       = 5'h04;
    localparam logic [4:0]  CIR_RESTORE    = 5'h06;
    localparam logic [4:0]  CIR_OPWORD     = 5'h08;
    localparam logic [4:0]  CIR_COMMAND    = 5'h0a;
    localparam logic [4:0]  CIR_CONDITION  = 5'h0e;
    localparam logic [4:0]  CIR_OPERAND    = 5'h10;
    localparam logic [4:0]  CIR_REGSEL     = 5'h14;
    localparam logic [4:0]  CIR_INSTADDR   = 5'h18;
    localparam logic [4:0]  CIR_OPADDR     = 5'h1c;

    // Wishbone register byte offsets of the processor end.
    localparam logic [7:0]  WB_OPWORD      = 8'h00;
    localparam logic [7:0]  WB_DATA        = 8'h04;
    localparam logic [7:0]  WB_MADDR       = 8'h08;
    localparam logic [7:0]  WB_CMD         = 8'h0c;
    localparam logic [7:0]  WB_STATUS      = 8'h10;
    localparam logic [7:0]  WB_EXT         = 8'h14;

    // Command register fields.
    localparam int          CMD_OP_LSB     = 0;
    localparam int          CMD_CAT_LSB    = 4;
    localparam int          CMD_SEL_LSB    = 8;
    localparam int          CMD_FC_LSB     = 16;
    localparam int          CMD_RD_BIT     = 20;

    // Command codes and instruction categories.
    localparam logic [2:0]  OP_CIR_WR      = 3'h0;
    localparam logic [2:0]  OP_CIR_RD      = 3'h1;
    localparam logic [2:0]  OP_START       = 3'h2;
    localparam logic [2:0]  OP_OPND_OUT    = 3'h3;
    localparam logic [2:0]  OP_OPND_IN     = 3'h4;
    localparam logic [2:0]  OP_ALT_MOVE    = 3'h5;
    localparam logic [1:0]  CAT_GENERAL    = 2'h0;
    localparam logic [1:0]  CAT_COND       = 2'h1;
    localparam logic [1:0]  CAT_SAVE       = 2'h2;
    localparam logic [1:0]  CAT_RESTORE    = 2'h3;

    // Status register fields.
    localparam int          ST_BUSY_BIT    = 0;
    localparam int          ST_FLINE_BIT   = 1;
    localparam int          ST_COPRO_BIT   = 2;
    localparam int          ST_UNIMPL_BIT  = 3;
    localparam int          ST_REFUSED_BIT = 4;
    localparam int          ST_COPROCESSOR_IDENTIFIER_FIELD_LSB    = 8;
    localparam int          ST_EXT_LSB     = 16;

    // Reset values.
    localparam logic [31:0] RST_WORD       = 32'h0000_0000;
    localparam logic [15:0] RST_HALF       = 16'h0000;
    localparam logic [7:0]  RST_COUNT      = 8'h00;

    typedef enum logic [1:0] {
        BS_IDLE,
        BS_WAIT_ACK,
        BS_WAIT_REL
    } cpa_bus_state_t;

    // Registers below the operand word are 16 bits wide, as is the
    // register selector; the rest carry a full longword.
    function automatic logic cpa_is_half(input logic [4:0] sel);
        cpa_is_half = (sel[4] == 1'b0) || (sel == CIR_REGSEL);
    endfunction : cpa_is_half

endpackage : cpa_pkg

// [rtl/cpa_bus_if.sv]
// Asynchronous-style bus joining the processor end and a coprocessor.
`timescale 1ns/1ps
`default_nettype none
interface cpa_bus_if;
    logic [2:0]  fc;
    logic [31:0] addr;
    logic        as;
    logic        rw;
    logic [31:0] p_data_o;
    logic        p_data_oe;
    logic [31:0] c_data_o;
    logic        c_data_oe;
    logic        c_ack;
    logic        c_ack_oe;
    logic [31:0] data;
    logic        ack;

    // The shared data wire and termination line resolved from enables.
    assign data = c_data_oe ? c_data_o : (p_data_oe ? p_data_o : 32'h0000_0000);
    assign ack  = c_ack_oe & c_ack;

    modport proc (
        output fc, addr, as, rw, p_data_o, p_data_oe,
        input  data, ack
    );
    modport copro (
        input  fc, addr, as, rw, data,
        output c_data_o, c_data_oe, c_ack, c_ack_oe
    );
endinterface : cpa_bus_if
`default_nettype wire

// [rtl/cpa_copro.sv]
// Coprocessor end: chip select and interface register file.
`timescale 1ns/1ps
`default_nettype none
module cpa_copro
    import cpa_pkg::*;
#(
    parameter logic [2:0] MY_COPROCESSOR_IDENTIFIER_FIELD = USER_COPROCESSOR_IDENTIFIER_FIELD_DFLT
) (
    // Clock and reset
    input  wire logic        MCLK,
    input  wire logic        RESETN,
    // Bus towards the processor
    cpa_bus_if.copro         BUS,
    // Words supplied by the coprocessor core
    input  wire logic [15:0] RESPONSE_WORD,
    input  wire logic [15:0] SAVE_WORD,
    input  wire logic [15:0] REGSEL_WORD,
    input  wire logic [31:0] OPERAND_RD,
    // Words and strobes towards the coprocessor core
    output logic      [15:0] CONTROL_WORD,
    output logic             CONTROL_STB,
    output logic      [15:0] RESTORE_WORD,
    output logic             RESTORE_STB,
    output logic      [15:0] OPCODE_WORD,
    output logic      [15:0] COMMAND_WORD,
    output logic             COMMAND_STB,
    output logic      [15:0] CONDITION_WORD,
    output logic             CONDITION_STB,
    output logic      [31:0] OPERAND_WR,
    output logic             OPERAND_WR_STB,
    output logic             OPERAND_RD_STB,
    output logic             RESPONSE_RD_STB,
    output logic      [31:0] INSTR_ADDR,
    output logic      [31:0] OPND_ADDR
);
    logic        served_r;
    logic        ack_r;
    logic        oe_r;
    logic [31:0] rdata_r;
    logic        hit;
    logic [4:0]  sel;
    logic [15:0] wlane;
    logic [15:0] rhalf;
    logic [31:0] rword;
    logic        take;

    // Only CPU-space coprocessor cycles with our own identifier select us.
    assign hit  = (BUS.fc == FC_CPU_SPACE) &&
                  (BUS.addr[19:16] == CYC_TYPE_COPRO) &&
                  (BUS.addr[15:13] == MY_COPROCESSOR_IDENTIFIER_FIELD);
    assign sel  = BUS.addr[4:0];
    assign take = BUS.as && hit && !served_r;
    assign wlane = sel[1] ? BUS.data[15:0] : BUS.data[31:16];

    always_comb begin
        rhalf = RST_HALF;
        rword = RST_WORD;
        case (sel)
            CIR_RESPONSE: rhalf = RESPONSE_WORD;
            CIR_SAVE:     rhalf = SAVE_WORD;
            CIR_RESTORE:  rhalf = RESTORE_WORD;
            CIR_REGSEL:   rhalf = REGSEL_WORD;
            CIR_OPERAND:  rword = OPERAND_RD;
            CIR_INSTADDR: rword = INSTR_ADDR;
            CIR_OPADDR:   rword = OPND_ADDR;
            default:      rhalf = RST_HALF;
        endcase
        if (cpa_is_half(sel)) begin
            rword = sel[1] ? {16'h0000, rhalf} : {rhalf, 16'h0000};
        end
    end

    // Termination and data drive; released as soon as the strobe falls.
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            served_r <= 1'b0;
            ack_r    <= 1'b0;
            oe_r     <= 1'b0;
            rdata_r  <= RST_WORD;
        end else if (!BUS.as) begin
            served_r <= 1'b0;
            ack_r    <= 1'b0;
            oe_r     <= 1'b0;
        end else if (take) begin
            served_r <= 1'b1;
            ack_r    <= 1'b1;
            oe_r     <= BUS.rw;
            rdata_r  <= rword;
        end
    end

    assign BUS.c_ack     = ack_r;
    assign BUS.c_ack_oe  = ack_r;
    assign BUS.c_data_o  = rdata_r;
    assign BUS.c_data_oe = oe_r;

    // Register writes and one-cycle strobes towards the core.
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            CONTROL_WORD    <= RST_HALF;
            RESTORE_WORD    <= RST_HALF;
            OPCODE_WORD     <= RST_HALF;
            COMMAND_WORD    <= RST_HALF;
            CONDITION_WORD  <= RST_HALF;
            OPERAND_WR      <= RST_WORD;
            INSTR_ADDR      <= RST_WORD;
            OPND_ADDR       <= RST_WORD;
            CONTROL_STB     <= 1'b0;
            RESTORE_STB     <= 1'b0;
            COMMAND_STB     <= 1'b0;
            CONDITION_STB   <= 1'b0;
            OPERAND_WR_STB  <= 1'b0;
            OPERAND_RD_STB  <= 1'b0;
            RESPONSE_RD_STB <= 1'b0;
        end else begin
            CONTROL_STB     <= take && !BUS.rw && (sel == CIR_CONTROL);
            RESTORE_STB     <= take && !BUS.rw && (sel == CIR_RESTORE);
            COMMAND_STB     <= take && !BUS.rw && (sel == CIR_COMMAND);
            CONDITION_STB   <= take && !BUS.rw && (sel == CIR_CONDITION);
            OPERAND_WR_STB  <= take && !BUS.rw && (sel == CIR_OPERAND);
            OPERAND_RD_STB  <= take && BUS.rw && (sel == CIR_OPERAND);
            RESPONSE_RD_STB <= take && BUS.rw && (sel == CIR_RESPONSE);
            if (take && !BUS.rw) begin
                case (sel)
                    CIR_CONTROL:   CONTROL_WORD   <= wlane;
                    CIR_RESTORE:   RESTORE_WORD   <= wlane;
                    CIR_OPWORD:    OPCODE_WORD    <= BUS.data[31:16];
                    CIR_COMMAND:   COMMAND_WORD   <= wlane;
                    CIR_CONDITION: CONDITION_WORD <= wlane;
                    CIR_OPERAND:   OPERAND_WR     <= BUS.data;
                    CIR_INSTADDR:  INSTR_ADDR     <= BUS.data;
                    CIR_OPADDR:    OPND_ADDR      <= BUS.data;
                    default:       CONTROL_WORD   <= CONTROL_WORD;
                endcase
            end
        end
    end
endmodule : cpa_copro
`default_nettype wire

// [tb/cpa_properties.sv]
// Concurrent checks on the bus that joins the processor and coprocessor.
`timescale 1ns/1ps
`default_nettype none
module cpa_properties
    import cpa_pkg::*;
#(
    parameter logic [2:0] MY_COPROCESSOR_IDENTIFIER_FIELD = USER_COPROCESSOR_IDENTIFIER_FIELD_DFLT
) (
    // Clock and reset
    input  wire logic        MCLK,
    input  wire logic        RESETN,
    // Bus signals
    input  wire logic [2:0]  fc,
    input  wire logic [31:0] addr,
    input  wire logic        as,
    input  wire logic        rw,
    input  wire logic        p_data_oe,
    input  wire logic        c_data_oe,
    input  wire logic        c_ack_oe,
    input  wire logic        ack
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RESETN);

    sequence cpu_cycle;
        as && fc == FC_CPU_SPACE;
    endsequence
    sequence own_take;
        $rose(as) && fc == FC_CPU_SPACE && addr[15:13] == MY_COPROCESSOR_IDENTIFIER_FIELD;
    endsequence

    AST_FC_CPU: assert property (as && addr[19:16] == CYC_TYPE_COPRO |-> fc == FC_CPU_SPACE) else $error("wrong function code");
    AST_CYC_TYPE: assert property (cpu_cycle |-> addr[19:16] == CYC_TYPE_COPRO) else $error("wrong cycle type");
    AST_NO_ZERO_ID: assert property (cpu_cycle |-> addr[15:13] != COPROCESSOR_IDENTIFIER_FIELD_NONE) else $error("identifier zero on bus");
    AST_ZERO_BITS: assert property (cpu_cycle |-> addr[31:20] == 12'h000 && addr[12:5] == 8'h00) else $error("address bits not zero");
    AST_STABLE: assert property (as && $past(as) |-> $stable(addr) && $stable(fc) && $stable(rw)) else $error("fields moved in cycle");
    AST_TAKE: assert property (own_take |-> ##[1:2] ack) else $error("no answer to own cycle");
    AST_RELEASE: assert property ($rose(ack) |-> as ##1 !as ##[1:2] !ack) else $error("handshake release wrong");
    AST_QUIET: assert property (!as && !$past(as) |-> !c_data_oe && !c_ack_oe) else $error("lines driven while idle");
    AST_READ: assert property (ack && rw |-> c_data_oe && !p_data_oe) else $error("read data not driven");
    AST_WRITE: assert property (as && ack && !rw |-> p_data_oe && !c_data_oe) else $error("write data not driven");
endmodule : cpa_properties
`default_nettype wire

// [tb/coprocessor_cpu_space_access_tb.sv]
// Self-checking bench joining both ends over the coprocessor bus.
`timescale 1ns/1ps
`default_nettype none
module coprocessor_cpu_space_access_tb
    import cpa_pkg::*;
;
    logic        MCLK, RESETN, WB_CYC, WB_STB, WB_WE, WB_ACK;
    logic [7:0]  WB_ADR;
    logic [3:0]  WB_SEL;
    logic [31:0] WB_DAT_I, WB_DAT_O, ord, opw, ia, oa, rdat, lfsr;
    logic [15:0] rsp, sav, rsl, ctl, rsw, opc, cmw, cnd;
    int          miscompares = 0;
    int          num_checks = 0;

    cpa_bus_if bus ();
    cpa_proc i_cpa_proc (.MCLK(MCLK), .RESETN(RESETN), .WB_CYC(WB_CYC),
        .WB_STB(WB_STB), .WB_WE(WB_WE), .WB_ADR(WB_ADR), .WB_SEL(WB_SEL),
        .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK(WB_ACK), .BUS(bus));
    cpa_copro #(.MY_COPROCESSOR_IDENTIFIER_FIELD(3'h6)) i_cpa_copro (.MCLK(MCLK), .RESETN(RESETN),
        .BUS(bus), .RESPONSE_WORD(rsp), .SAVE_WORD(sav), .REGSEL_WORD(rsl),
        .OPERAND_RD(ord), .CONTROL_WORD(ctl), .CONTROL_STB(),
        .RESTORE_WORD(rsw), .RESTORE_STB(), .OPCODE_WORD(opc),
        .COMMAND_WORD(cmw), .COMMAND_STB(), .CONDITION_WORD(cnd),
        .CONDITION_STB(), .OPERAND_WR(opw), .OPERAND_WR_STB(),
        .OPERAND_RD_STB(), .RESPONSE_RD_STB(), .INSTR_ADDR(ia),
        .OPND_ADDR(oa));
    cpa_properties #(.MY_COPROCESSOR_IDENTIFIER_FIELD(3'h6)) i_cpa_properties (.MCLK(MCLK),
        .RESETN(RESETN), .fc(bus.fc), .addr(bus.addr), .as(bus.as),
        .rw(bus.rw), .p_data_oe(bus.p_data_oe), .c_data_oe(bus.c_data_oe),
        .c_ack_oe(bus.c_ack_oe), .ack(bus.ack));

    initial begin
        MCLK = 1'b0;
        forever #4 MCLK = ~MCLK;
    end

    task automatic complete_run();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction : rnd

    // Classic cycle: request held until ack is sampled, then released.
    task automatic wb(input logic we, input logic [7:0] a,
                      input logic [31:0] d);
        int n = 0;
        @(posedge MCLK);
        {WB_CYC, WB_STB, WB_WE, WB_ADR, WB_DAT_I} <= {2'b11, we, a, d};
        do begin
            @(posedge MCLK);
            n++;
        end while (WB_ACK !== 1'b1 && n < 64);
        rdat = WB_DAT_O;
        {WB_CYC, WB_STB} <= 2'b00;
        if (n >= 64) begin
            miscompares++;
            complete_run();
        end
    endtask : wb

    // Busy must clear within a bounded number of polls.
    task automatic run(input logic [2:0] op, input logic [1:0] cat,
                       input logic [4:0] sel, input logic [4:0] fr = 5'h00);
        wb(1'b1, WB_CMD, {11'h000, fr, 3'h0, sel, 2'b00, cat, 1'b0, op});
        for (int n = 0; n < 40; n++) begin
            wb(1'b0, WB_STATUS, 32'h0000_0000);
            if (rdat[ST_BUSY_BIT] === 1'b0) return;
        end
        miscompares++;
        complete_run();
    endtask : run

    function automatic logic [31:0] st_exp(input logic [15:0] w);
        logic fl;
        fl = (w[15:12] == 4'hf);
        return {21'h0, w[11:9], 5'h0, fl && w[11:9] != 3'h0, fl, 1'b0};
    endfunction : st_exp

    function automatic logic [31:0] obs(input logic [4:0] s);
        case (s)
            CIR_CONTROL:   return {16'h0000, ctl};
            CIR_RESTORE:   return {16'h0000, rsw};
            CIR_OPWORD:    return {16'h0000, opc};
            CIR_COMMAND:   return {16'h0000, cmw};
            CIR_CONDITION: return {16'h0000, cnd};
            CIR_OPERAND:   return opw;
            CIR_INSTADDR:  return ia;
            default:       return oa;
        endcase
    endfunction : obs

    function automatic logic [31:0] rd_exp(input logic [4:0] s);
        case (s)
            CIR_RESPONSE: return {16'h0000, rsp};
            CIR_SAVE:     return {16'h0000, sav};
            CIR_REGSEL:   return {16'h0000, rsl};
            CIR_OPERAND:  return ord;
            default:      return 32'h0000_0000;
        endcase
    endfunction : rd_exp

    initial begin
        logic [31:0] d;
        logic [15:0] w;
        static logic [4:0] wsel [8] = '{5'h02, 5'h06, 5'h08, 5'h0a,
                                        5'h0e, 5'h10, 5'h18, 5'h1c};
        static logic [4:0] rsel [5] = '{5'h00, 5'h04, 5'h14, 5'h10,
                                        5'h0c};
        {WB_CYC, WB_STB, WB_WE, WB_ADR, WB_DAT_I} = '0;
        WB_SEL = 4'hf;
        RESETN = 1'b0;
        lfsr = 32'h0001_3eb5;
        {rsp, sav} = rnd();
        {rsl, ord} = {16'(rnd()), rnd()};
        repeat (4) @(posedge MCLK);
        RESETN <= 1'b1;
        wb(1'b0, WB_STATUS, 32'h0000_0000);
        chk(rdat, 32'h0000_0000);
        wb(1'b0, 8'hfc, 32'h0000_0000);
        chk(rdat, 32'h0000_0000);
        for (int i = 0; i < 9; i++) begin
            w = 16'(rnd());
            w[15:9] = (i < 8) ? {4'hf, 3'(i)} : {1'b0, w[14:9]};
            wb(1'b1, WB_OPWORD, {16'h0000, w});
            wb(1'b0, WB_STATUS, 32'h0000_0000);
            chk(rdat & 32'h0000_0706, st_exp(w));
        end
        wb(1'b1, WB_OPWORD, 32'h0000_f040);
        run(OP_CIR_WR, CAT_GENERAL, CIR_OPERAND);
        chk({30'h0, rdat[4:3]}, 32'h0000_0003);
        wb(1'b1, WB_STATUS, 32'h0000_0018);
        wb(1'b0, WB_STATUS, 32'h0000_0000);
        chk({30'h0, rdat[4:3]}, 32'h0000_0000);
        wb(1'b1, WB_OPWORD, 32'h0000_fc00);
        foreach (wsel[i]) begin
            d = rnd();
            wb(1'b1, WB_DATA, d);
            run(OP_CIR_WR, CAT_GENERAL, wsel[i]);
            chk(obs(wsel[i]), wsel[i] < 5'h10 ? {16'h0, d[15:0]} : d);
        end
        foreach (rsel[i]) begin
            run(OP_CIR_RD, CAT_GENERAL, rsel[i]);
            wb(1'b0, WB_DATA, 32'h0000_0000);
            chk(rdat, rd_exp(rsel[i]));
        end
        for (int c = 0; c < 4; c++) begin
            d = rnd();
            wb(1'b1, WB_DATA, d);
            run(OP_START, 2'(c), 5'h00);
            wb(1'b0, WB_DATA, 32'h0000_0000);
            chk(c == 0 ? cmw : c == 1 ? cnd : c == 2 ? rdat[15:0] : rsw,
                c == 2 ? sav : d[15:0]);
        end
        // A second order while the first is still on the bus is refused.
        wb(1'b1, WB_CMD, {27'h000_0000, 5'h0});
        run(OP_CIR_WR, CAT_GENERAL, CIR_CONTROL);
        chk({31'h0, rdat[ST_REFUSED_BIT]}, 32'h0000_0001);
        repeat (3) wb(1'b1, WB_EXT, 32'h0000_1234);
        wb(1'b0, WB_STATUS, 32'h0000_0000);
        chk({24'h0, rdat[23:16]}, 32'h0000_0003);
        // Memory-side steps aimed at the coprocessor's own address words.
        wb(1'b1, WB_MADDR, 32'h0002_c018);
        run(OP_OPND_OUT, CAT_GENERAL, CIR_OPERAND, 5'h07);
        chk(ia, ord);
        run(OP_OPND_IN, CAT_GENERAL, CIR_OPERAND, 5'h07);
        chk(opw, ord);
        // The raw move is the only cycle allowed with identifier zero.
        wb(1'b1, WB_OPWORD, 32'h0000_f000);
        d = rnd();
        wb(1'b1, WB_DATA, d);
        wb(1'b1, WB_MADDR, 32'h0002_c01c);
        run(OP_ALT_MOVE, CAT_GENERAL, 5'h00, 5'h07);
        chk(oa, d);
        complete_run();
    end
endmodule : coprocessor_cpu_space_access_tb
`default_nettype wire
